// ---- core/peak_detector_consts.vh ----
// Overview of operation
// - Peak and crossing logic runs only while the detector enable bit is 1.
// - Block length is an unsigned linear 17-bit count of reduced samples.
// - A reduced sample is the largest magnitude of eight converter samples.
// - Block length sits in bits 7:0, bits 15:8 and bit 0 of a third register.
// - Four 8-bit thresholds on a 0 to 256 scale, 256 being full peak.
// - A flag sets when the block peak rises above its comparator's set level.
// - A set flag clears after the peak stays below clear level for hold time.
// - Hold time is a 16-bit count of clock cycles in two registers.
// - A high comparator and a low comparator each drive one output flag.
`ifndef PEAK_DETECTOR_CONSTS_VH
`define PEAK_DETECTOR_CONSTS_VH

// ==========================================================
// Register offsets
`define ADDR_ENABLE_CTRL    8'h00
`define ADDR_BLK_LEN_LOW    8'h01
`define ADDR_BLK_LEN_MID    8'h02
`define ADDR_BLK_LEN_TOP    8'h03
`define ADDR_HIGH_SET       8'h07
`define ADDR_HIGH_CLEAR     8'h08
`define ADDR_LOW_SET        8'h09
`define ADDR_LOW_CLEAR      8'h0a
`define ADDR_HOLD_LOW       8'h0b
`define ADDR_HOLD_HIGH      8'h0c
`define ADDR_IRQ_STATUS     8'h20
`define ADDR_IRQ_MASK       8'h21
`define ADDR_FLAG_STATE     8'h22
`define ADDR_PEAK_LOW       8'h23
`define ADDR_PEAK_TOP       8'h24

// ==========================================================
// Field positions
`define BIT_ENABLE          0
`define BIT_BLK_LEN_TOP     0
`define EV_HIGH_SET         0
`define EV_LOW_SET          1
`define EV_BLOCK_DONE       2
`define EV_COUNT            3

// ==========================================================
// Reset values and scale
`define RST_REG8            8'h00
`define RST_BLK_LEN         17'h0_0000
`define RST_HOLD            16'h0000
`define GROUP_SIZE          8
`define PEAK_SCALE_W        9

`endif

// ---- core/hysteresis_flag.v ----
`timescale 1ns/1ns
module hysteresis_flag (
  input  wire        i_clk,
  input  wire        i_sys_rst,
  input  wire        i_enable,
  input  wire        i_eval,
  input  wire [8:0]  i_peak,
  input  wire [7:0]  i_set_level,
  input  wire [7:0]  i_clear_level,
  input  wire [15:0] i_hold,
  output reg         o_flag
);

  reg        below;
  reg [15:0] hold_time_high_cnt;

  wire above_set = i_peak > {1'b0, i_set_level};
  wire under_clr = i_peak < {1'b0, i_clear_level};

  // ==========================================================
  // Set and hold_time_high-qualified clear
  always @(posedge i_clk) begin
    if (i_sys_rst || !i_enable) begin
      o_flag    <= 1'b0;
      below     <= 1'b0;
      hold_time_high_cnt <= 16'h0000;
    end else if (i_eval) begin
      if (above_set) begin
        o_flag    <= 1'b1;
        below     <= 1'b0;
        hold_time_high_cnt <= 16'h0000;
      end else if (under_clr) begin
        if (!below) begin
          below     <= 1'b1;
          hold_time_high_cnt <= 16'h0000;
          if (i_hold == 16'h0000)
            o_flag <= 1'b0;
        end else if (o_flag && hold_time_high_cnt >= i_hold) begin
          o_flag <= 1'b0;
        end else if (hold_time_high_cnt != 16'hffff) begin
          hold_time_high_cnt <= hold_time_high_cnt + 16'h0001;
        end
      end else begin
        // Peak back in band breaks the run
        below     <= 1'b0;
        hold_time_high_cnt <= 16'h0000;
      end
    end else if (o_flag && below) begin
      if (hold_time_high_cnt >= i_hold)
        o_flag <= 1'b0;
      else
        hold_time_high_cnt <= hold_time_high_cnt + 16'h0001;
    end
  end

endmodule // hysteresis_flag

// ---- core/block_peak_detector.v ----
// The strobed register port was decided locally.
`timescale 1ns/1ns
`include "peak_detector_consts.vh"
module block_peak_detector #(
  parameter SAMPLE_W = 14
) (
  input  wire                  i_clk,
  input  wire                  i_sys_rst,
  input  wire                  i_sample_valid,
  input  wire [8*SAMPLE_W-1:0] i_samples,
  input  wire [7:0]            i_addr,
  input  wire [7:0]            i_wr_data,
  input  wire                  i_wr_en,
  input  wire                  i_rd_en,
  output reg  [7:0]            o_rd_data,
  output wire                  o_high_flag,
  output wire                  o_low_flag,
  output wire                  o_irq
);

  // ==========================================================
  // Register file state
  reg                  detector_enable;
  reg [16:0]           block_length;
  reg [7:0]            high_set_level;
  reg [7:0]            high_clear_level;
  reg [7:0]            low_set_level;
  reg [7:0]            low_clear_level;
  reg [15:0]           hold_time;
  reg [`EV_COUNT-1:0]  irq_status;
  reg [`EV_COUNT-1:0]  irq_mask;

  // ==========================================================
  // Datapath state
  reg [SAMPLE_W-1:0]   reduced_mag;
  reg                  reduced_valid;
  reg [SAMPLE_W-1:0]   block_max;
  reg [16:0]           block_cnt;
  reg                  block_done;
  reg [8:0]            block_peak;
  reg [1:0]            flags_q;

  wire [SAMPLE_W-1:0]  lane_mag [0:7];
  wire [SAMPLE_W-1:0]  run_max  [0:7];
  wire [1:0]           flags;
  wire [SAMPLE_W-1:0]  candidate;
  wire [16:0]          length_eff;
  wire                 last_in_block;
  wire [`EV_COUNT-1:0] events;
  wire [`EV_COUNT-1:0] wr_clear;
  wire [8:0]           scaled_candidate;

  // ==========================================================
  // Magnitude per lane and running maximum
  genvar g;
  generate
    for (g = 0; g < `GROUP_SIZE; g = g + 1) begin : g_lane
      wire [SAMPLE_W-1:0] raw = i_samples[g*SAMPLE_W +: SAMPLE_W];
      // Most negative code maps to 2^(W-1), still fits unsigned
      assign lane_mag[g] = raw[SAMPLE_W-1] ? (~raw + 1'b1) : raw;
      if (g == 0) begin : g_first
        assign run_max[g] = lane_mag[g];
      end else begin : g_rest
        assign run_max[g] = (lane_mag[g] > run_max[g-1]) ?
                            lane_mag[g] : run_max[g-1];
      end
    end
  endgenerate

  // ==========================================================
  // Reduced sample register
  always @(posedge i_clk) begin
    if (i_sys_rst || !detector_enable) begin
      reduced_mag   <= {SAMPLE_W{1'b0}};
      reduced_valid <= 1'b0;
    end else begin
      reduced_mag   <= run_max[`GROUP_SIZE-1];
      reduced_valid <= i_sample_valid;
    end
  end

  // ==========================================================
  // Block accumulation
  // Zero length would end a block on every reduced sample, so it acts as one
  assign length_eff    = (block_length == 17'h0_0000) ?
                         17'h0_0001 : block_length;
  assign last_in_block = (block_cnt + 17'h0_0001) >= length_eff;
  assign candidate     = (block_cnt == 17'h0_0000) ? reduced_mag :
                         ((reduced_mag > block_max) ?
                          reduced_mag : block_max);
  // Top nine bits give 0..256 of full scale
  assign scaled_candidate =
    candidate[SAMPLE_W-1:SAMPLE_W-`PEAK_SCALE_W];

  always @(posedge i_clk) begin
    if (i_sys_rst || !detector_enable) begin
      block_max  <= {SAMPLE_W{1'b0}};
      block_cnt  <= 17'h0_0000;
      block_done <= 1'b0;
      block_peak <= 9'h000;
    end else begin
      block_done <= 1'b0;
      if (reduced_valid) begin
        if (last_in_block) begin
          block_cnt  <= 17'h0_0000;
          block_max  <= {SAMPLE_W{1'b0}};
          block_done <= 1'b1;
          block_peak <= scaled_candidate;
        end else begin
          block_cnt <= block_cnt + 17'h0_0001;
          block_max <= candidate;
        end
      end
    end
  end

  // ==========================================================
  // High and low comparators
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_cmp
      wire [7:0] set_lvl = (g == 0) ? high_set_level : low_set_level;
      wire [7:0] clr_lvl = (g == 0) ? high_clear_level : low_clear_level;
      hysteresis_flag u_flag (
        .i_clk         (i_clk),
        .i_sys_rst     (i_sys_rst),
        .i_enable      (detector_enable),
        .i_eval        (block_done),
        .i_peak        (block_peak),
        .i_set_level   (set_lvl),
        .i_clear_level (clr_lvl),
        .i_hold        (hold_time),
        .o_flag        (flags[g])
      );
    end
  endgenerate

  assign o_high_flag = flags[0];
  assign o_low_flag  = flags[1];

  always @(posedge i_clk) begin
    if (i_sys_rst)
      flags_q <= 2'b00;
    else
      flags_q <= flags;
  end

  // ==========================================================
  // Interrupt status, mask and output
  assign events[`EV_HIGH_SET]   = flags[0] & ~flags_q[0];
  assign events[`EV_LOW_SET]    = flags[1] & ~flags_q[1];
  assign events[`EV_BLOCK_DONE] = block_done;
  assign wr_clear = (i_wr_en && i_addr == `ADDR_IRQ_STATUS) ?
                    i_wr_data[`EV_COUNT-1:0] : {`EV_COUNT{1'b0}};

  always @(posedge i_clk) begin
    if (i_sys_rst)
      irq_status <= {`EV_COUNT{1'b0}};
    else
      // New event beats a same-cycle clear
      irq_status <= (irq_status & ~wr_clear) | events;
  end

  assign o_irq = |(irq_status & irq_mask);

  // ==========================================================
  // Register writes
  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      detector_enable  <= 1'b0;
      block_length     <= `RST_BLK_LEN;
      high_set_level   <= `RST_REG8;
      high_clear_level <= `RST_REG8;
      low_set_level    <= `RST_REG8;
      low_clear_level  <= `RST_REG8;
      hold_time        <= `RST_HOLD;
      irq_mask         <= {`EV_COUNT{1'b0}};
    end else if (i_wr_en) begin
      case (i_addr)
        `ADDR_ENABLE_CTRL:
          detector_enable <= i_wr_data[`BIT_ENABLE];
        `ADDR_BLK_LEN_LOW:
          block_length[7:0] <= i_wr_data;
        `ADDR_BLK_LEN_MID:
          block_length[15:8] <= i_wr_data;
        `ADDR_BLK_LEN_TOP:
          block_length[16] <= i_wr_data[`BIT_BLK_LEN_TOP];
        `ADDR_HIGH_SET:
          high_set_level <= i_wr_data;
        `ADDR_HIGH_CLEAR:
          high_clear_level <= i_wr_data;
        `ADDR_LOW_SET:
          low_set_level <= i_wr_data;
        `ADDR_LOW_CLEAR:
          low_clear_level <= i_wr_data;
        `ADDR_HOLD_LOW:
          hold_time[7:0] <= i_wr_data;
        `ADDR_HOLD_HIGH:
          hold_time[15:8] <= i_wr_data;
        `ADDR_IRQ_MASK:
          irq_mask <= i_wr_data[`EV_COUNT-1:0];
        default: begin
        end
      endcase
    end
  end

  // ==========================================================
  // Register reads, data one cycle after the strobe
  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_rd_data <= 8'h00;
    end else if (i_rd_en) begin
      case (i_addr)
        `ADDR_ENABLE_CTRL: o_rd_data <= {7'h00, detector_enable};
        `ADDR_BLK_LEN_LOW: o_rd_data <= block_length[7:0];
        `ADDR_BLK_LEN_MID: o_rd_data <= block_length[15:8];
        `ADDR_BLK_LEN_TOP: o_rd_data <= {7'h00, block_length[16]};
        `ADDR_HIGH_SET:    o_rd_data <= high_set_level;
        `ADDR_HIGH_CLEAR:  o_rd_data <= high_clear_level;
        `ADDR_LOW_SET:     o_rd_data <= low_set_level;
        `ADDR_LOW_CLEAR:   o_rd_data <= low_clear_level;
        `ADDR_HOLD_LOW:    o_rd_data <= hold_time[7:0];
        `ADDR_HOLD_HIGH:   o_rd_data <= hold_time[15:8];
        `ADDR_IRQ_STATUS:  o_rd_data <= {5'h00, irq_status};
        `ADDR_IRQ_MASK:    o_rd_data <= {5'h00, irq_mask};
        `ADDR_FLAG_STATE:  o_rd_data <= {6'h00, flags};
        `ADDR_PEAK_LOW:    o_rd_data <= block_peak[7:0];
        `ADDR_PEAK_TOP:    o_rd_data <= {7'h00, block_peak[8]};
        // Unmapped reads answer zero
        default:           o_rd_data <= 8'h00;
      endcase
    end else begin
      o_rd_data <= 8'h00;
    end
  end

endmodule // block_peak_detector

// ---- bench/block_peak_detector_assertions.sv ----
`timescale 1ns/1ns
// ==========
// Port checker
module block_peak_detector_checker #(
  parameter SAMPLE_W = 14
) (
  input wire logic                  i_clk,
  input wire logic                  i_sys_rst,
  input wire logic                  i_sample_valid,
  input wire logic [8*SAMPLE_W-1:0] i_samples,
  input wire logic [7:0]            i_addr,
  input wire logic [7:0]            i_wr_data,
  input wire logic                  i_wr_en,
  input wire logic                  i_rd_en,
  input wire logic [7:0]            o_rd_data,
  input wire logic                  o_high_flag,
  input wire logic                  o_low_flag,
  input wire logic                  o_irq
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  logic       en;
  logic [2:0] mask;
  // Shadow of enable and mask, so no internal probing is needed
  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      en <= 1'b0;
      mask <= 3'h0;
    end else if (i_wr_en && i_addr == 8'h00) begin
      en <= i_wr_data[0];
    end else if (i_wr_en && i_addr == 8'h21) begin
      mask <= i_wr_data[2:0];
    end
  end
  property p_rd_idle;
    !i_rd_en |=> o_rd_data == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
  property p_en_bits;
    i_rd_en && i_addr == 8'h00 |=> o_rd_data == {7'h00, en};
  endproperty
  a_en_bits: assert property (p_en_bits) else $error("enable readback");
  property p_top_bit;
    i_rd_en && i_addr == 8'h03 |=> o_rd_data[7:1] == 7'h00;
  endproperty
  a_top_bit: assert property (p_top_bit) else $error("top bit reg");
  property p_set_rw;
    i_wr_en && i_addr == 8'h07 ##1 i_rd_en && i_addr == 8'h07
      |=> o_rd_data == $past(i_wr_data, 2);
  endproperty
  a_set_rw: assert property (p_set_rw) else $error("threshold readback");
  property p_rise_h;
    $rose(o_high_flag) |-> $past(i_sample_valid, 3);
  endproperty
  a_rise_h: assert property (p_rise_h) else $error("high flag w/o block");
  property p_rise_l;
    $rose(o_low_flag) |-> $past(i_sample_valid, 3);
  endproperty
  a_rise_l: assert property (p_rise_l) else $error("low flag w/o block");
  property p_off;
    !en ##1 !en |-> !o_high_flag && !o_low_flag;
  endproperty
  a_off: assert property (p_off) else $error("flag while disabled");
  property p_irq_mask;
    mask == 3'h0 |-> !o_irq;
  endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("irq masked");
  property p_rst;
    @(posedge i_clk) disable iff (1'b0) i_sys_rst
      |=> o_rd_data == 8'h00 && !o_high_flag && !o_low_flag && !o_irq;
  endproperty
  a_rst: assert property (p_rst) else $error("reset state");
  c_high: cover property ($rose(o_high_flag));
  c_low: cover property ($rose(o_low_flag));
  c_clear: cover property ($fell(o_high_flag) && en);
  c_irq: cover property ($rose(o_irq));
endmodule // block_peak_detector_checker

// ---- bench/agc_monitor.sv ----
`timescale 1ns/1ns
// ==========
// Alarm consumer
module agc_monitor (
  input  wire logic       i_clk,
  input  wire logic       i_sys_rst,
  input  wire logic       i_high_flag,
  input  wire logic       i_low_flag,
  output logic [7:0] o_high_rises,
  output logic [7:0] o_low_rises
);
  logic high_q;
  logic low_q;
  // Onsets only; a gain loop reacts to new alarms
  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      high_q <= 1'b0;
      low_q <= 1'b0;
      o_high_rises <= 8'h00;
      o_low_rises <= 8'h00;
    end else begin
      high_q <= i_high_flag;
      low_q <= i_low_flag;
      if (i_high_flag && !high_q) o_high_rises <= o_high_rises + 8'h01;
      if (i_low_flag && !low_q) o_low_rises <= o_low_rises + 8'h01;
    end
  end
endmodule // agc_monitor

// ---- bench/tb.sv ----
`timescale 1ns/1ns
// ==========
// Testbench
module tb;
  localparam SAMPLE_W = 14;
  logic         i_clk, i_sys_rst, i_sample_valid, i_wr_en, i_rd_en;
  logic [111:0] i_samples;
  logic [7:0]   i_addr, i_wr_data, o_rd_data, hr, lr;
  logic         o_high_flag, o_low_flag, o_irq;
  logic [7:0]   regs [10];
  logic [7:0]   vals [10];
  int           mismatches, compares;
  block_peak_detector #(.SAMPLE_W(SAMPLE_W)) u_block_peak_detector (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_sample_valid(i_sample_valid),
    .i_samples(i_samples), .i_addr(i_addr), .i_wr_data(i_wr_data),
    .i_wr_en(i_wr_en), .i_rd_en(i_rd_en), .o_rd_data(o_rd_data),
    .o_high_flag(o_high_flag), .o_low_flag(o_low_flag), .o_irq(o_irq));
  agc_monitor u_agc (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
    .i_high_flag(o_high_flag), .i_low_flag(o_low_flag),
    .o_high_rises(hr), .o_low_rises(lr));
  task chk(input logic [7:0] s, input logic [7:0] e);
    compares++;
    if (s !== e) begin
      mismatches++;
      $display("mismatch at %0t: got %h want %h", $time, s, e);
    end
  endtask
  // Write strobe stays up so a read can follow with no gap
  task wr(input logic [7:0] a, input logic [7:0] d);
    i_wr_en <= 1'b1;
    i_rd_en <= 1'b0;
    i_addr <= a;
    i_wr_data <= d;
    @(posedge i_clk);
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e);
    i_wr_en <= 1'b0;
    i_rd_en <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd_en <= 1'b0;
    #1 chk(o_rd_data, e);
    @(posedge i_clk);
  endtask
  task idle(input int n);
    i_wr_en <= 1'b0;
    repeat (n) @(posedge i_clk);
  endtask
  // One group of eight lanes, then a gap cycle that must not count
  task grp(input int k, input logic [13:0] v);
    logic [111:0] s;
    s = {8{14'h0040}};
    s[k*14 +: 14] = v;
    i_wr_en <= 1'b0;
    i_sample_valid <= 1'b1;
    i_samples <= s;
    @(posedge i_clk);
    i_sample_valid <= 1'b0;
    @(posedge i_clk);
  endtask
  task conclude;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  initial begin
    #100000;
    mismatches++;
    conclude;
  end
  initial begin
    {i_sys_rst, i_sample_valid, i_wr_en, i_rd_en} = 4'h8;
    {i_samples, i_addr, i_wr_data} = '0;
    regs = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h07, 8'h08, 8'h09, 8'h0a,
             8'h0b, 8'h0c};
    vals = '{8'h01, 8'h03, 8'h00, 8'h00, 8'h10, 8'h08, 8'h60, 8'h08,
             8'h14, 8'h00};
    repeat (6) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    for (int i = 0; i < 10; i++) rd(regs[i], 8'h00);
    rd(8'h05, 8'h00);
    $display("test reset values done");
    for (int i = 0; i < 10; i++) begin
      wr(regs[i], 8'h5b + i[7:0]);
      rd(regs[i], (i == 0 || i == 3) ? {7'h00, ~i[0]} : 8'h5b + i[7:0]);
    end
    $display("test register access done");
    for (int i = 0; i < 10; i++) wr(regs[i], vals[i]);
    wr(8'h21, 8'h01);
    grp(0, 14'h3c00);
    grp(2, 14'h0040);
    idle(4);
    chk(o_high_flag, 8'h00);
    grp(7, 14'h0040);
    idle(4);
    chk(o_high_flag, 8'h01);
    chk(o_low_flag, 8'h00);
    chk(o_irq, 8'h01);
    rd(8'h23, 8'h20);
    wr(8'h20, 8'h01);
    idle(1);
    chk(o_irq, 8'h00);
    rd(8'h20, 8'h04);
    $display("test high comparator done");
    repeat (3) grp(5, 14'h1000);
    idle(4);
    chk(o_low_flag, 8'h01);
    chk(o_high_flag, 8'h01);
    repeat (3) grp(1, 14'h0040);
    idle(19);
    chk({o_low_flag, o_high_flag}, 8'h03);
    rd(8'h22, 8'h03);
    chk({o_low_flag, o_high_flag}, 8'h03);
    idle(2);
    chk({o_low_flag, o_high_flag}, 8'h00);
    rd(8'h23, 8'h02);
    rd(8'h20, 8'h06);
    $display("test hold time done");
    repeat (3) grp(4, 14'h0400);
    idle(4);
    chk(o_high_flag, 8'h01);
    chk(o_irq, 8'h01);
    wr(8'h00, 8'h00);
    idle(2);
    chk(o_high_flag, 8'h00);
    repeat (3) grp(6, 14'h1000);
    idle(4);
    chk({o_low_flag, o_high_flag}, 8'h00);
    chk(hr, 8'h02);
    chk(lr, 8'h01);
    $display("test disable done");
    i_sys_rst <= 1'b1;
    @(posedge i_clk);
    i_sys_rst <= 1'b0;
    rd(8'h20, 8'h00);
    chk(o_irq, 8'h00);
    $display("test mid-run reset done");
    conclude;
  end
endmodule // tb
bind block_peak_detector block_peak_detector_checker #(
  .SAMPLE_W(SAMPLE_W)) u_chk (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
  .i_sample_valid(i_sample_valid), .i_samples(i_samples),
  .i_addr(i_addr), .i_wr_data(i_wr_data), .i_wr_en(i_wr_en),
  .i_rd_en(i_rd_en), .o_rd_data(o_rd_data), .o_high_flag(o_high_flag),
  .o_low_flag(o_low_flag), .o_irq(o_irq));
